/* File: hdl/card_window_socket_control_regs.sv */
// two-socket window offset, card detect, global control and page decode block
`timescale 1ns/100ps
`default_nettype none
`include "card_window_defines.svh"
module card_window_socket_control_regs (
    input  wire logic                       I_CLK,
    input  wire logic                       I_RST,
    input  wire logic                       I_CE,
    input  wire logic                       I_REG_SOCK,
    input  wire card_window_pkg::reg_addr_t I_REG_ADDR,
    input  wire logic                       I_REG_WR,
    input  wire logic                       I_REG_RD,
    input  wire card_window_pkg::reg_byte_t I_REG_WDATA,
    output card_window_pkg::reg_byte_t      O_REG_RDATA,
    output logic                            O_REG_ACK,
    input  wire logic [1:0]                 I_VOLTAGE_SENSE_ONE,
    input  wire logic [1:0]                 I_VOLTAGE_SENSE_TWO,
    input  wire logic [1:0]                 I_CARD_PRESENT_A_N,
    input  wire logic [1:0]                 I_CARD_PRESENT_B_N,
    input  wire logic [1:0]                 I_CD_ENABLE,
    input  wire logic [1:0]                 I_CSC_CLEAR,
    output logic      [1:0]                 O_SW_CD_EVENT,
    output logic      [1:0]                 O_RING_WAKE_OUT_N,
    output logic                            O_INT_LEVEL_B,
    output logic                            O_INT_LEVEL_A,
    output logic                            O_CSC_WRITEBACK_CLEAR,
    output logic                            O_CSC_INT_LEVEL,
    output logic                            O_LOW_POWER_SELECT,
    input  wire logic                       I_MEM_REQ,
    input  wire logic                       I_MEM_SOCK,
    input  wire logic                       I_MEM_WRITE,
    input  wire card_window_pkg::host_addr_t I_MEM_ADDR,
    output logic                            O_MEM_HIT,
    output logic                            O_MEM_ATTR,
    output logic                            O_MEM_WR_BLOCKED,
    output card_window_pkg::card_addr_t     O_MEM_CARD_ADDR,
    input  wire logic                       I_CARD_CYCLE,
    output logic                            O_CARD_OE_N,
    input  wire logic                       I_DMA_REQ,
    input  wire logic [1:0]                 I_FUNC_IRQ,
    output logic                            O_DMA_REQ,
    output logic      [1:0]                 O_FUNC_IRQ
);
    localparam int NSOCK = 2;

    card_window_pkg::reg_byte_t global_r, global_nxt;
    card_window_pkg::reg_byte_t page_r, page_nxt;
    card_window_pkg::reg_byte_t rdata_r, rdata_nxt;
    logic                       ack_r, ack_nxt;
    card_window_pkg::reg_byte_t sock_rdata [NSOCK];
    card_window_pkg::reg_byte_t sock_win_hi [NSOCK];
    card_window_pkg::reg_byte_t sock_win_lo [NSOCK];
    logic       [NSOCK-1:0]     vs_one_s, vs_two_s, pres_a_s, pres_b_s;
    logic                       dma_s;
    logic       [NSOCK-1:0]     irq_s;

    logic                       hit_r, hit_nxt;
    logic                       attr_r, attr_nxt;
    logic                       wrblk_r, wrblk_nxt;
    card_window_pkg::card_addr_t caddr_r, caddr_nxt;
    logic                       oe_n_r, oe_n_nxt;
    logic                       dma_r, dma_nxt;
    logic       [NSOCK-1:0]     irq_r, irq_nxt;
    card_window_pkg::reg_byte_t win_hi, win_lo;
    logic                       page_match;

    function automatic logic shared_reg(input card_window_pkg::reg_addr_t a);
        return (a == `CW_OFF_GLOBAL) || (a == `CW_OFF_PAGE);
    endfunction : shared_reg

    function automatic card_window_pkg::card_addr_t card_addr(
        input card_window_pkg::host_addr_t host,
        input card_window_pkg::reg_byte_t hi,
        input card_window_pkg::reg_byte_t lo);
        logic [26:0] sum;
        sum = {1'b0, host[`CW_CARD_MSB:0]} + {1'b0, hi[`CW_OFS_MSB:0], lo, `CW_ZERO_LOW};
        return sum[`CW_CARD_MSB:0];
    endfunction : card_addr

    // pin inputs from the socket cross into the clock domain here
    // empty-socket pins rest high, so the synchronised copies start high and no false detect edge follows reset
    cw_sync2 #(.WIDTH(4 * NSOCK), .RST_VAL('1)) u_sync_socket (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_ce    (I_CE),
        .i_async ({I_VOLTAGE_SENSE_ONE, I_VOLTAGE_SENSE_TWO, I_CARD_PRESENT_A_N, I_CARD_PRESENT_B_N}),
        .o_sync  ({vs_one_s, vs_two_s, pres_a_s, pres_b_s})
    );

    cw_sync2 #(.WIDTH(NSOCK + 1)) u_sync_req (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_ce    (I_CE),
        .i_async ({I_DMA_REQ, I_FUNC_IRQ}),
        .o_sync  ({dma_s, irq_s})
    );

    for (genvar k = 0; k < NSOCK; k++) begin : g_sock
        cw_socket_regs u_regs (
            .i_clk         (I_CLK),
            .i_rst         (I_RST),
            .i_ce          (I_CE),
            .i_sel         (I_REG_SOCK == k[0]),
            .i_wr          (I_REG_WR),
            .i_addr        (I_REG_ADDR),
            .i_wdata       (I_REG_WDATA),
            .i_vs_one      (vs_one_s[k]),
            .i_vs_two      (vs_two_s[k]),
            .i_present_a_n (pres_a_s[k]),
            .i_present_b_n (pres_b_s[k]),
            .i_cd_enable   (I_CD_ENABLE[k]),
            .i_csc_clear   (I_CSC_CLEAR[k]),
            .o_rdata       (sock_rdata[k]),
            .o_win_hi      (sock_win_hi[k]),
            .o_win_lo      (sock_win_lo[k]),
            .o_sw_cd_event (O_SW_CD_EVENT[k]),
            .o_ring_wake_n (O_RING_WAKE_OUT_N[k])
        );
    end

    // shared registers and read path; either socket view reaches the same global
    always_comb begin
        global_nxt = global_r;
        page_nxt   = page_r;
        rdata_nxt  = rdata_r;
        ack_nxt    = 1'b0;
        if (I_REG_WR && I_REG_ADDR == `CW_OFF_GLOBAL) begin
            global_nxt = I_REG_WDATA & `CW_GL_MASK;
        end
        if (I_REG_WR && I_REG_ADDR == `CW_OFF_PAGE) begin
            page_nxt = I_REG_WDATA;
        end
        if (I_REG_RD) begin
            if (I_REG_ADDR == `CW_OFF_GLOBAL) begin
                rdata_nxt = global_r;
            end else if (shared_reg(I_REG_ADDR)) begin
                rdata_nxt = page_r;
            end else begin
                rdata_nxt = sock_rdata[I_REG_SOCK];
            end
        end
        ack_nxt = I_REG_RD || I_REG_WR;
        if (!I_CE) begin
            global_nxt = global_r;
            page_nxt   = page_r;
            rdata_nxt  = rdata_r;
            ack_nxt    = ack_r;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            global_r <= `CW_RST_BYTE;
            page_r   <= `CW_RST_BYTE;
            rdata_r  <= `CW_RST_BYTE;
            ack_r    <= 1'b0;
        end else begin
            global_r <= global_nxt;
            page_r   <= page_nxt;
            rdata_r  <= rdata_nxt;
            ack_r    <= ack_nxt;
        end
    end

    // memory window translation for socket-side cycles
    always_comb begin
        win_hi     = sock_win_hi[I_MEM_SOCK];
        win_lo     = sock_win_lo[I_MEM_SOCK];
        page_match = (I_MEM_ADDR[`CW_PAGE_MSB:`CW_PAGE_LSB] == page_r);
        hit_nxt    = I_MEM_REQ && page_match;
        attr_nxt   = win_hi[`CW_ATTR_BIT];
        wrblk_nxt  = I_MEM_REQ && page_match && I_MEM_WRITE && win_hi[`CW_WP_BIT];
        caddr_nxt  = card_addr(I_MEM_ADDR, win_hi, win_lo);
        // outputs float in power-down unless a card cycle runs
        oe_n_nxt   = global_r[`CW_GL_PD_BIT] && !I_CARD_CYCLE;
        // requests pass regardless of power-down
        dma_nxt    = dma_s;
        irq_nxt    = irq_s;
        if (!I_CE) begin
            hit_nxt   = hit_r;
            attr_nxt  = attr_r;
            wrblk_nxt = wrblk_r;
            caddr_nxt = caddr_r;
            oe_n_nxt  = oe_n_r;
            dma_nxt   = dma_r;
            irq_nxt   = irq_r;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            hit_r   <= 1'b0;
            attr_r  <= 1'b0;
            wrblk_r <= 1'b0;
            caddr_r <= '0;
            oe_n_r  <= 1'b0;
            dma_r   <= 1'b0;
            irq_r   <= '0;
        end else begin
            hit_r   <= hit_nxt;
            attr_r  <= attr_nxt;
            wrblk_r <= wrblk_nxt;
            caddr_r <= caddr_nxt;
            oe_n_r  <= oe_n_nxt;
            dma_r   <= dma_nxt;
            irq_r   <= irq_nxt;
        end
    end

    assign O_REG_RDATA           = rdata_r;
    assign O_REG_ACK             = ack_r;
    assign O_INT_LEVEL_B         = global_r[`CW_GL_LVB_BIT];
    assign O_INT_LEVEL_A         = global_r[`CW_GL_LVA_BIT];
    assign O_CSC_WRITEBACK_CLEAR = global_r[`CW_GL_WB_BIT];
    assign O_CSC_INT_LEVEL       = global_r[`CW_GL_CSCLV_BIT];
    assign O_LOW_POWER_SELECT    = global_r[`CW_GL_PD_BIT];
    assign O_MEM_HIT             = hit_r;
    assign O_MEM_ATTR            = attr_r;
    assign O_MEM_WR_BLOCKED      = wrblk_r;
    assign O_MEM_CARD_ADDR       = caddr_r;
    assign O_CARD_OE_N           = oe_n_r;
    assign O_DMA_REQ             = dma_r;
    assign O_FUNC_IRQ            = irq_r;

    a_page_decode: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE && I_MEM_REQ |=> O_MEM_HIT == ($past(I_MEM_ADDR[`CW_PAGE_MSB:`CW_PAGE_LSB]) == $past(page_r)))
        else $error("page decode mismatch");
    a_low_region: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE && I_MEM_REQ && page_r == `CW_RST_BYTE && I_MEM_ADDR[`CW_PAGE_MSB:`CW_PAGE_LSB] != `CW_RST_BYTE
        |=> !O_MEM_HIT)
        else $error("window decoded above lowest region");
    a_wp_block: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE && I_MEM_REQ && I_MEM_WRITE && page_match |=> O_MEM_WR_BLOCKED == $past(win_hi[`CW_WP_BIT]))
        else $error("write protect not applied");
    a_wp_read_ok: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE && !I_MEM_WRITE |=> !O_MEM_WR_BLOCKED)
        else $error("read blocked by write protect");
    a_attr_select: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE |=> O_MEM_ATTR == $past(win_hi[`CW_ATTR_BIT]))
        else $error("attribute select wrong");
    a_card_top: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE && I_MEM_ADDR[`CW_CARD_MSB:0] == '0
        |=> O_MEM_CARD_ADDR == {$past(win_hi[`CW_OFS_MSB:0]), $past(win_lo), `CW_ZERO_LOW})
        else $error("offset bits not on card address");
    a_powerdown_oe: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE && O_LOW_POWER_SELECT && !I_CARD_CYCLE ##1 I_CE && I_CARD_CYCLE |-> O_CARD_OE_N ##1 !O_CARD_OE_N)
        else $error("card outputs not floated in power-down");
    a_drive_normal: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE && !O_LOW_POWER_SELECT |=> !O_CARD_OE_N)
        else $error("card outputs floated outside power-down");
    a_dma_pass: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE [*3] ##0 O_LOW_POWER_SELECT |=> O_DMA_REQ == $past(dma_s))
        else $error("dma request lost in power-down");
    a_global_shared: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE && I_REG_WR && I_REG_ADDR == `CW_OFF_GLOBAL
        |=> global_r == ($past(I_REG_WDATA) & `CW_GL_MASK) && global_r[7:5] == 3'h0)
        else $error("global control not shared or reserved bits set");
    a_read_ack: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE && I_REG_RD && I_REG_ADDR == `CW_OFF_CD_CTL |=> O_REG_ACK && O_REG_RDATA[`CW_SWCD_BIT] == 1'b0
        && O_REG_RDATA[3:2] == 2'h0 && O_REG_RDATA[0] == 1'b0)
        else $error("card detect control read wrong");
    a_mode_out: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE && I_REG_WR && I_REG_ADDR == `CW_OFF_GLOBAL
        |=> {O_INT_LEVEL_B, O_INT_LEVEL_A, O_CSC_WRITEBACK_CLEAR, O_CSC_INT_LEVEL, O_LOW_POWER_SELECT}
            == $past(I_REG_WDATA[`CW_GL_LVB_BIT:`CW_GL_PD_BIT]))
        else $error("global mode outputs wrong");
    a_page_write: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE && I_REG_WR && I_REG_ADDR == `CW_OFF_PAGE |=> page_r == $past(I_REG_WDATA))
        else $error("page register not written");
    a_page_read: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE && I_REG_RD && I_REG_ADDR == `CW_OFF_PAGE |=> O_REG_RDATA == $past(page_r))
        else $error("page register read wrong");
    a_irq_pass: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE [*3] ##0 O_LOW_POWER_SELECT |=> O_FUNC_IRQ == $past(irq_s))
        else $error("functional interrupt lost in power-down");
    a_miss_no_block: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CE && !(I_MEM_REQ && page_match) |=> !O_MEM_WR_BLOCKED)
        else $error("write blocked outside a window hit");
endmodule : card_window_socket_control_regs
`default_nettype wire

/* File: hdl/cw_socket_regs.sv */
// per-socket card detect control, window offsets and ring wake output
`timescale 1ns/100ps
`default_nettype none
`include "card_window_defines.svh"
module cw_socket_regs (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    input  wire logic                      i_ce,
    input  wire logic                      i_sel,
    input  wire logic                      i_wr,
    input  wire card_window_pkg::reg_addr_t i_addr,
    input  wire card_window_pkg::reg_byte_t i_wdata,
    input  wire logic                      i_vs_one,
    input  wire logic                      i_vs_two,
    input  wire logic                      i_present_a_n,
    input  wire logic                      i_present_b_n,
    input  wire logic                      i_cd_enable,
    input  wire logic                      i_csc_clear,
    output card_window_pkg::reg_byte_t     o_rdata,
    output card_window_pkg::reg_byte_t     o_win_hi,
    output card_window_pkg::reg_byte_t     o_win_lo,
    output logic                           o_sw_cd_event,
    output logic                           o_ring_wake_n
);
    card_window_pkg::reg_byte_t regs_r [6];
    card_window_pkg::reg_byte_t regs_nxt [6];
    logic       resume_r, resume_nxt, rmrst_r, rmrst_nxt;
    logic       swcd_r, swcd_nxt, ring_n_r, ring_n_nxt;
    logic [1:0] det_r, det_nxt;
    logic       removal, change;

    // index order: window lo, window hi, io0 lo, io0 hi, io1 lo, io1 hi
    always_comb begin
        regs_nxt   = regs_r;
        resume_nxt = resume_r;
        rmrst_nxt  = rmrst_r;
        swcd_nxt   = 1'b0;
        det_nxt    = {i_present_b_n, i_present_a_n};
        change     = (det_nxt != det_r);
        removal    = (det_r == 2'b00) && (det_nxt != 2'b00);
        ring_n_nxt = ring_n_r;
        if (i_sel && i_wr) begin
            case (i_addr)
                `CW_OFF_WIN4_LO: regs_nxt[0] = i_wdata;
                `CW_OFF_WIN4_HI: regs_nxt[1] = i_wdata;
                `CW_OFF_IO0_LO:  regs_nxt[2] = i_wdata;
                `CW_OFF_IO0_HI:  regs_nxt[3] = i_wdata;
                `CW_OFF_IO1_LO:  regs_nxt[4] = i_wdata;
                `CW_OFF_IO1_HI:  regs_nxt[5] = i_wdata;
                `CW_OFF_CD_CTL: begin
                    resume_nxt = i_wdata[`CW_RESUME_BIT];
                    rmrst_nxt  = i_wdata[`CW_RMRST_BIT];
                    swcd_nxt   = i_wdata[`CW_SWCD_BIT] && i_cd_enable;
                end
                default: ;
            endcase
        end
        if (rmrst_r && removal) begin
            regs_nxt   = '{default: `CW_RST_BYTE};
            resume_nxt = 1'b0;
            rmrst_nxt  = 1'b0;
        end
        // a new detect change wins over the clear in the same cycle
        if (i_csc_clear) ring_n_nxt = 1'b1;
        if (resume_r && change) ring_n_nxt = 1'b0;
        if (!i_ce) begin
            regs_nxt   = regs_r;
            resume_nxt = resume_r;
            rmrst_nxt  = rmrst_r;
            swcd_nxt   = swcd_r;
            det_nxt    = det_r;
            ring_n_nxt = ring_n_r;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            regs_r   <= '{default: `CW_RST_BYTE};
            resume_r <= 1'b0;
            rmrst_r  <= 1'b0;
            swcd_r   <= 1'b0;
            det_r    <= 2'b11;
            ring_n_r <= 1'b1;
        end else begin
            regs_r   <= regs_nxt;
            resume_r <= resume_nxt;
            rmrst_r  <= rmrst_nxt;
            swcd_r   <= swcd_nxt;
            det_r    <= det_nxt;
            ring_n_r <= ring_n_nxt;
        end
    end

    always_comb begin
        o_rdata = `CW_RST_BYTE;
        case (i_addr)
            `CW_OFF_WIN4_LO: o_rdata = regs_r[0];
            `CW_OFF_WIN4_HI: o_rdata = regs_r[1];
            `CW_OFF_IO0_LO:  o_rdata = regs_r[2];
            `CW_OFF_IO0_HI:  o_rdata = regs_r[3];
            `CW_OFF_IO1_LO:  o_rdata = regs_r[4];
            `CW_OFF_IO1_HI:  o_rdata = regs_r[5];
            `CW_OFF_CD_CTL: begin
                // write-only and reserved bits stay zero
                o_rdata[`CW_VS2_BIT]    = i_vs_two;
                o_rdata[`CW_VS1_BIT]    = i_vs_one;
                o_rdata[`CW_RESUME_BIT] = resume_r;
                o_rdata[`CW_RMRST_BIT]  = rmrst_r;
            end
            default: ;
        endcase
    end

    assign o_win_lo      = regs_r[0];
    assign o_win_hi      = regs_r[1];
    assign o_sw_cd_event = swcd_r;
    assign o_ring_wake_n = ring_n_r;

    a_swcd_gated: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_sel && i_wr && i_addr == `CW_OFF_CD_CTL |=> o_sw_cd_event == $past(i_wdata[`CW_SWCD_BIT] && i_cd_enable))
        else $error("software card detect event wrong");
    a_ring_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_ring_wake_n && !i_csc_clear |=> !o_ring_wake_n)
        else $error("ring wake released without clear");
    a_ring_fall: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && resume_r && change |=> !o_ring_wake_n)
        else $error("ring wake did not fall on detect change");
endmodule : cw_socket_regs
`default_nettype wire

/* File: hdl/cw_sync2.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module cw_sync2 #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    always_comb begin
        meta_nxt = i_ce ? i_async : meta_r;
        sync_nxt = i_ce ? meta_r : sync_r;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign o_sync = sync_r;
endmodule : cw_sync2
`default_nettype wire

/* File: inc/card_window_defines.svh */
// register offsets, bit positions and reset values of the socket window block
`ifndef CARD_WINDOW_DEFINES_SVH
`define CARD_WINDOW_DEFINES_SVH
`define CW_OFF_CD_CTL   12'h816
`define CW_OFF_GLOBAL   12'h81E
`define CW_OFF_WIN4_LO  12'h834
`define CW_OFF_WIN4_HI  12'h835
`define CW_OFF_IO0_LO   12'h836
`define CW_OFF_IO0_HI   12'h837
`define CW_OFF_IO1_LO   12'h838
`define CW_OFF_IO1_HI   12'h839
`define CW_OFF_PAGE     12'h840
`define CW_WP_BIT       7
`define CW_ATTR_BIT     6
`define CW_OFS_MSB      5
`define CW_VS2_BIT      7
`define CW_VS1_BIT      6
`define CW_SWCD_BIT     5
`define CW_RESUME_BIT   4
`define CW_RMRST_BIT    1
`define CW_GL_LVB_BIT   4
`define CW_GL_LVA_BIT   3
`define CW_GL_WB_BIT    2
`define CW_GL_CSCLV_BIT 1
`define CW_GL_PD_BIT    0
`define CW_GL_MASK      8'h1F
`define CW_RST_BYTE     8'h00
`define CW_PAGE_MSB     31
`define CW_PAGE_LSB     24
`define CW_CARD_MSB     25
`define CW_ZERO_LOW     12'h000
`endif

/* File: inc/card_window_pkg.sv */
// shared types of the socket window block
package card_window_pkg;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [11:0] reg_addr_t;
    typedef logic [25:0] card_addr_t;
    typedef logic [31:0] host_addr_t;
endpackage : card_window_pkg

/* File: verif/card_socket_model.sv */
// card-side model: detect and voltage-sense pins of two sockets
`timescale 1ns/100ps
`default_nettype none
module card_socket_model #(
    parameter logic [1:0] VS_ONE = 2'b10,
    parameter logic [1:0] VS_TWO = 2'b01
) (
    input  wire logic [1:0] i_inserted,
    output logic      [1:0] o_present_a_n,
    output logic      [1:0] o_present_b_n,
    output logic      [1:0] o_vs_one,
    output logic      [1:0] o_vs_two
);
    // an empty socket leaves every pin on its pull-up
    assign o_present_a_n = ~i_inserted;
    assign o_present_b_n = ~i_inserted;
    assign o_vs_one      = VS_ONE | ~i_inserted;
    assign o_vs_two      = VS_TWO | ~i_inserted;
endmodule : card_socket_model
`default_nettype wire

/* File: verif/tb_card_window_socket_control_regs.sv */
// self-checking bench of the two-socket window and control registers
`timescale 1ns/100ps
`default_nettype none
module tb_card_window_socket_control_regs;
    logic                        clk, rst, sock, wr, rd, ack, mreq, msock, mwr, cyc, dma, odma, oe_n;
    logic                        lvb, lva, wbc, csclv, lps, hit, attr, blk;
    logic [1:0]                  ins, cd_en, clr, vs1, vs2, pa_n, pb_n, swcd, ring, firq, ofirq;
    card_window_pkg::reg_addr_t  addr;
    card_window_pkg::reg_byte_t  wd, rdat;
    card_window_pkg::host_addr_t maddr;
    card_window_pkg::card_addr_t caddr;
    int                          bad_count = 0;
    int                          cmp_count = 0;

    card_socket_model u_card (.i_inserted(ins), .o_present_a_n(pa_n), .o_present_b_n(pb_n),
        .o_vs_one(vs1), .o_vs_two(vs2));
    card_window_socket_control_regs u_dut (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_REG_SOCK(sock),
        .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wd), .O_REG_RDATA(rdat),
        .O_REG_ACK(ack), .I_VOLTAGE_SENSE_ONE(vs1), .I_VOLTAGE_SENSE_TWO(vs2), .I_CARD_PRESENT_A_N(pa_n),
        .I_CARD_PRESENT_B_N(pb_n), .I_CD_ENABLE(cd_en), .I_CSC_CLEAR(clr), .O_SW_CD_EVENT(swcd),
        .O_RING_WAKE_OUT_N(ring), .O_INT_LEVEL_B(lvb), .O_INT_LEVEL_A(lva), .O_CSC_WRITEBACK_CLEAR(wbc),
        .O_CSC_INT_LEVEL(csclv), .O_LOW_POWER_SELECT(lps), .I_MEM_REQ(mreq), .I_MEM_SOCK(msock),
        .I_MEM_WRITE(mwr), .I_MEM_ADDR(maddr), .O_MEM_HIT(hit), .O_MEM_ATTR(attr), .O_MEM_WR_BLOCKED(blk),
        .O_MEM_CARD_ADDR(caddr), .I_CARD_CYCLE(cyc), .O_CARD_OE_N(oe_n), .I_DMA_REQ(dma),
        .I_FUNC_IRQ(firq), .O_DMA_REQ(odma), .O_FUNC_IRQ(ofirq));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // each access idles one cycle after its acknowledge
    task automatic wr_reg(input logic s, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        sock = s;
        addr = a;
        wd = d;
        wr = 1'b1;
        @(posedge clk) #1;
        wr = 1'b0;
        chk(ack, 1);
    endtask : wr_reg

    task automatic rd_reg(input logic s, input logic [11:0] a, input logic [7:0] e);
        @(posedge clk) #1;
        sock = s;
        addr = a;
        rd = 1'b1;
        @(posedge clk) #1;
        rd = 1'b0;
        chk(rdat, e);
    endtask : rd_reg

    task automatic mem(input logic s, input logic w, input logic [31:0] a, input logic [2:0] e,
        input logic [25:0] ec);
        msock = s;
        mwr = w;
        maddr = a;
        mreq = 1'b1;
        @(posedge clk) #1;
        chk({hit, attr, blk}, e);
        chk(caddr, ec);
    endtask : mem

    task automatic stop_test();
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        stop_test();
    end

    initial begin
        {rst, sock, wr, rd, mreq, msock, mwr, cyc, dma} = 9'h100;
        {ins, cd_en, clr, firq} = 8'hC0;
        addr = 12'h000;
        wd = 8'h00;
        maddr = 32'h00000000;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        rd_reg(1, 12'h840, 8'h00);
        rd_reg(1, 12'h800, 8'h00);
        mem(1, 0, 32'h00000010, 3'h4, 26'h0000010);
        mem(1, 0, 32'h01000010, 3'h0, 26'h1000010);
        wr_reg(1, 12'h81E, 8'hFF);
        chk({lvb, lva, wbc, csclv, lps}, 5'h1F);
        rd_reg(0, 12'h81E, 8'h1F);
        cyc = 1'b1;
        @(posedge clk) #1;
        chk(oe_n, 0);
        cyc = 1'b0;
        dma = 1'b1;
        firq = 2'b10;
        @(posedge clk) #1;
        chk(oe_n, 1);
        repeat (3) @(posedge clk);
        #1;
        chk({odma, ofirq}, 3'h6);
        wr_reg(0, 12'h81E, 8'hEA);
        chk({lvb, lva, wbc, csclv, lps}, 5'h0A);
        cd_en = 2'b01;
        wr_reg(0, 12'h816, 8'hFF);
        chk(swcd, 2'b01);
        rd_reg(0, 12'h816, 8'h92);
        wr_reg(1, 12'h816, 8'h20);
        chk(swcd, 2'b00);
        rd_reg(1, 12'h816, 8'h40);
        wr_reg(0, 12'h834, 8'h45);
        wr_reg(0, 12'h835, 8'hC3);
        wr_reg(1, 12'h835, 8'h07);
        wr_reg(0, 12'h840, 8'h12);
        mem(0, 1, 32'h120000FF, 3'h7, 26'h23450FF);
        mem(0, 1, 32'h13FFF000, 3'h2, 26'h0344000);
        mem(1, 1, 32'h12000000, 3'h4, 26'h2700000);
        mem(0, 0, 32'h14000000, 3'h2, 26'h0345000);
        mreq = 1'b0;
        ins = 2'b00;
        repeat (6) @(posedge clk);
        #1;
        chk(ring, 2'b10);
        rd_reg(0, 12'h835, 8'h00);
        rd_reg(1, 12'h835, 8'h07);
        rd_reg(0, 12'h816, 8'hC0);
        chk(ring, 2'b10);
        clr = 2'b01;
        @(posedge clk) #1;
        clr = 2'b00;
        chk(ring, 2'b11);
        stop_test();
    end
endmodule : tb_card_window_socket_control_regs
`default_nettype wire
